// [include/ichmux_pkg.sv]
// Shared constants and types for the I2C channel multiplexer and its host controller
package ichmux_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Device addressing and control byte layout
  localparam logic [3:0] DEV_ADDR_HI = 4'he;
  localparam int CTRL_EN_BIT = 2;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_IRQ_LSB = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;

  ////////////////////////////////////////////////////////////////////////
  // Host register map (AXI4-Lite, byte addresses)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CMD_RW_BIT = 0;
  localparam int CMD_WDATA_LSB = 8;
  localparam int CMD_ADDR_LSB = 16;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_NACK_BIT = 1;
  localparam int ST_IRQ_BIT = 2;
  localparam int ST_RDATA_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int SYS_CLK_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * SYS_CLK_NS);

  ////////////////////////////////////////////////////////////////////////
  // State machines
  typedef enum logic [6:0] {
    D_IDLE = 7'h01, D_ADDR = 7'h02, D_ACK_A = 7'h04, D_WR = 7'h08,
    D_ACK_W = 7'h10, D_RD = 7'h20, D_MACK = 7'h40
  } ichmux_dst_t;

  typedef enum logic [3:0] {
    M_IDLE = 4'h1, M_START = 4'h2, M_BIT = 4'h4, M_STOP = 4'h8
  } ichmux_mst_t;

endpackage : ichmux_pkg

// [include/ichmux_if.sv]
// Two-wire bus plus interrupt line joining the host controller and the multiplexer
`timescale 1ns/1ps
interface ichmux_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic irq_o;
  logic irq_oe;
  // Resolved open-drain wires, pulled up when nobody drives
  logic scl;
  logic sda;
  logic irq_n;

  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_d_oe);
  assign irq_n = ~irq_oe;

  modport host (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda, irq_n);
  modport dev (output sda_d_o, sda_d_oe, irq_o, irq_oe, input scl, sda);
endinterface : ichmux_if

// [rtl/ichmux_dev.sv]
// Four-channel multiplexer control logic: two-wire slave, control register, interrupts
`timescale 1ns/1ps
module ichmux_dev
  import ichmux_pkg::*;
#(
  parameter logic [3:0] ADDR_HI = DEV_ADDR_HI
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Two-wire bus and interrupt output
  ichmux_if.dev bus,
  // Address straps
  input wire logic addr_strap_0,
  input wire logic addr_strap_1,
  input wire logic addr_strap_2,
  // Downstream interrupt inputs
  input wire logic chan0_irq_in_n,
  input wire logic chan1_irq_in_n,
  input wire logic chan2_irq_in_n,
  input wire logic chan3_irq_in_n,
  // Switch fabric channel enables, one-hot or all clear
  output logic [3:0] chan_select
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [8:0] sy1;
    logic [8:0] sy2;
    logic scl_p;
    logic sda_p;
    ichmux_dst_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic sda_oe;
    logic irq_oe;
    logic [3:0] ctrl;
    logic [3:0] pend_val;
    logic pend;
    logic [3:0] chan_sel;
  } ichmux_dstate_t;

  ichmux_dstate_t st_r;
  ichmux_dstate_t st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Decoded bus events, all from the second synchroniser stage

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [2:0] strap;
  logic [3:0] irq_n;
  logic [7:0] rd_byte;
  logic [3:0] new_sel;

  assign scl = st_r.sy2[0];
  assign sda = st_r.sy2[1];
  assign irq_n = st_r.sy2[5:2];
  assign strap = st_r.sy2[8:6];
  assign scl_rise = scl & ~st_r.scl_p;
  assign scl_fall = ~scl & st_r.scl_p;
  assign start_det = scl & st_r.scl_p & st_r.sda_p & ~sda;
  assign stop_det = scl & st_r.scl_p & ~st_r.sda_p & sda;

  // Status is sampled at the moment the byte is loaded for shifting
  assign rd_byte = {~irq_n, st_r.ctrl};

  // At most one channel can ever be enabled
  assign new_sel = st_r.pend_val[CTRL_EN_BIT]
                   ? (4'h1 << st_r.pend_val[CTRL_SEL_LSB +: 2])
                   : 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.sy1 = {addr_strap_2, addr_strap_1, addr_strap_0,
                  chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n,
                  bus.sda, bus.scl};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.scl_p = scl;
    st_nxt.sda_p = sda;
    // Not filtered: a glitch on an input reaches the output as a glitch
    st_nxt.irq_oe = ~&irq_n;

    if (start_det) begin
      // A start anywhere, repeated or not, restarts address reception
      st_nxt.st = D_ADDR;
      st_nxt.cnt = 4'h0;
      st_nxt.sda_oe = 1'b0;
    end else if (stop_det) begin
      st_nxt.st = D_IDLE;
      st_nxt.sda_oe = 1'b0;
      if (st_r.pend) begin
        // Switching only here keeps every line high when a channel connects
        st_nxt.ctrl = st_r.pend_val;
        st_nxt.chan_sel = new_sel;
        st_nxt.pend = 1'b0;
      end
    end else if (scl_rise) begin
      if (st_r.st != D_IDLE) begin
        st_nxt.cnt = 4'(st_r.cnt + 4'h1);
      end
      if (st_r.st == D_ADDR || st_r.st == D_WR) begin
        st_nxt.sh = {st_r.sh[6:0], sda};
      end
      if (st_r.st == D_MACK && sda) begin
        // Not-acknowledge ends the read; the line is already free
        st_nxt.st = D_IDLE;
        st_nxt.sda_oe = 1'b0;
      end
    end else if (scl_fall) begin
      case (st_r.st)
        D_ADDR: begin
          if (st_r.cnt == BITS_PER_BYTE) begin
            if (st_r.sh[7:4] == ADDR_HI && st_r.sh[3:1] == strap) begin
              st_nxt.sda_oe = 1'b1;
              st_nxt.rw = st_r.sh[0];
              st_nxt.st = D_ACK_A;
            end else begin
              st_nxt.st = D_IDLE;
            end
          end
        end
        D_ACK_A: begin
          if (st_r.cnt == ACK_SLOT) begin
            st_nxt.cnt = 4'h0;
            if (st_r.rw) begin
              st_nxt.sh = rd_byte;
              st_nxt.sda_oe = ~rd_byte[7];
              st_nxt.st = D_RD;
            end else begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.st = D_WR;
            end
          end
        end
        D_WR: begin
          if (st_r.cnt == BITS_PER_BYTE) begin
            // Each new byte overwrites the pending one
            st_nxt.pend_val = st_r.sh[3:0];
            st_nxt.pend = 1'b1;
            st_nxt.sda_oe = 1'b1;
            st_nxt.st = D_ACK_W;
          end
        end
        D_ACK_W: begin
          if (st_r.cnt == ACK_SLOT) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.cnt = 4'h0;
            st_nxt.st = D_WR;
          end
        end
        D_RD: begin
          if (st_r.cnt == BITS_PER_BYTE) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.st = D_MACK;
          end else begin
            // Data changes only while the clock is low
            st_nxt.sh = {st_r.sh[6:0], 1'b0};
            st_nxt.sda_oe = ~st_r.sh[6];
          end
        end
        D_MACK: begin
          if (st_r.cnt == ACK_SLOT) begin
            // Master acknowledged: send the status again, freshly sampled
            st_nxt.cnt = 4'h0;
            st_nxt.sh = rd_byte;
            st_nxt.sda_oe = ~rd_byte[7];
            st_nxt.st = D_RD;
          end
        end
        default: begin
          st_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.st <= D_IDLE;
      // Synchronisers rest at the idle pin level, so no false edge or interrupt follows reset
      st_r.sy1 <= '1;
      st_r.sy2 <= '1;
      st_r.scl_p <= 1'b1;
      st_r.sda_p <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus.sda_d_o = 1'b0;
  assign bus.sda_d_oe = st_r.sda_oe;
  assign bus.irq_o = 1'b0;
  assign bus.irq_oe = st_r.irq_oe;
  assign chan_select = st_r.chan_sel;

endmodule : ichmux_dev

// [rtl/ichmux_host.sv]
// Host controller: AXI4-Lite registers driving single-byte transfers to the multiplexer
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module ichmux_host
  import ichmux_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Two-wire bus
  ichmux_if.host bus
);

  if (QTR < 8 || QTR > 65535) begin : g_chk
    $error("QTR must lie in 8..65535");
  end

  typedef struct packed {
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic awready, wready, bvalid, arready, rvalid, aw_got, w_got;
    logic [1:0] bresp, rresp;
    logic [7:0] aw_addr;
    logic [31:0] wd, rdata;
    ichmux_mst_t st;
    logic [1:0] q;
    logic [15:0] qc;
    logic [3:0] bitn;
    logic byten, rw, nack, scl_oe, sda_oe;
    logic [7:0] abyte, wbyte, rbyte;
  } ichmux_hstate_t;

  ichmux_hstate_t st_r;
  ichmux_hstate_t st_nxt;
  logic sda;
  logic tick;
  logic txbit;
  logic [2:0] idx;
  logic [31:0] status;

  assign sda = st_r.sy2[0];
  assign tick = st_r.qc == 16'(QTR - 1);
  assign idx = 3'(3'h7 - st_r.bitn[2:0]);
  // A read data byte leaves the line released, including its final not-acknowledge
  assign txbit = st_r.byten ? (st_r.rw | st_r.wbyte[idx]) : st_r.abyte[idx];
  assign status = {16'h0, st_r.rbyte, 5'h0, st_r.sy2[1], st_r.nack, st_r.st != M_IDLE};

  always_comb begin
    st_nxt = st_r;
    st_nxt.sy1 = {bus.irq_n, bus.sda};
    st_nxt.sy2 = st_r.sy1;

    ////////////////////////////////////////////////////////////////////////
    // Register slave
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wd = s_axi_wdata;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (st_r.aw_addr == REG_CMD) begin
        // Commands while busy are dropped so a transfer is never cut short
        if (st_r.st == M_IDLE) begin
          st_nxt.abyte = {st_r.wd[CMD_ADDR_LSB +: 7], st_r.wd[CMD_RW_BIT]};
          st_nxt.wbyte = st_r.wd[CMD_WDATA_LSB +: 8];
          st_nxt.rw = st_r.wd[CMD_RW_BIT];
          st_nxt.nack = 1'b0;
          st_nxt.q = 2'h0;
          st_nxt.qc = 16'h0;
          st_nxt.st = M_START;
        end
      end else if (st_r.aw_addr != REG_STAT) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = (s_axi_araddr == REG_STAT) ? status : 32'h0;
      st_nxt.rresp = (s_axi_araddr == REG_STAT || s_axi_araddr == REG_CMD)
                     ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.w_got & ~st_nxt.bvalid;
    st_nxt.arready = ~st_nxt.rvalid;

    ////////////////////////////////////////////////////////////////////////
    // Bit engine: four quarter periods per bus clock
    if (st_r.st != M_IDLE) begin
      st_nxt.qc = tick ? 16'h0 : 16'(st_r.qc + 16'h1);
      if (tick) begin
        st_nxt.q = 2'(st_r.q + 2'h1);
        case (st_r.st)
          M_START: begin
            if (st_r.q == 2'h0) begin
              st_nxt.sda_oe = 1'b1;
            end else begin
              st_nxt.scl_oe = 1'b1;
              st_nxt.st = M_BIT;
              st_nxt.q = 2'h0;
              st_nxt.bitn = 4'h0;
              st_nxt.byten = 1'b0;
            end
          end
          M_BIT: begin
            case (st_r.q)
              2'h0: st_nxt.sda_oe = (st_r.bitn < BITS_PER_BYTE) & ~txbit;
              2'h1: st_nxt.scl_oe = 1'b0;
              2'h2: begin
                if (st_r.bitn == BITS_PER_BYTE) begin
                  // Address and write bytes need the device's acknowledge
                  if (sda && (!st_r.byten || !st_r.rw)) begin
                    st_nxt.nack = 1'b1;
                  end
                end else if (st_r.byten && st_r.rw) begin
                  st_nxt.rbyte = {st_r.rbyte[6:0], sda};
                end
              end
              default: begin
                st_nxt.scl_oe = 1'b1;
                st_nxt.bitn = 4'(st_r.bitn + 4'h1);
                if (st_r.bitn == BITS_PER_BYTE) begin
                  st_nxt.bitn = 4'h0;
                  if (st_r.nack || st_r.byten) begin
                    st_nxt.st = M_STOP;
                  end else begin
                    st_nxt.byten = 1'b1;
                  end
                end
              end
            endcase
          end
          M_STOP: begin
            case (st_r.q)
              2'h0: st_nxt.sda_oe = 1'b1;
              2'h1: st_nxt.scl_oe = 1'b0;
              2'h2: st_nxt.sda_oe = 1'b0;
              default: begin
                // Final quarter keeps a bus-free gap before the next start
                st_nxt.st = M_IDLE;
                st_nxt.qc = 16'h0;
              end
            endcase
          end
          default: st_nxt.st = M_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.st <= M_IDLE;
      // Idle line level, so status never shows a phantom interrupt after reset
      st_r.sy1 <= '1;
      st_r.sy2 <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe = st_r.scl_oe;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = st_r.sda_oe;

endmodule : ichmux_host

// [tb/ichmux_assertions.sv]
// Concurrent checks on the two-wire link, interrupt line and channel select
`timescale 1ns/1ps
module ichmux_assertions
  import ichmux_pkg::*;
#(
  parameter logic [3:0] ADDR_HI = DEV_ADDR_HI
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link wires and device drives
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe,
  input wire logic irq_oe,
  // Device pins
  input wire logic [3:0] chan_select,
  input wire logic chan0_irq_in_n,
  input wire logic chan1_irq_in_n,
  input wire logic chan2_irq_in_n,
  input wire logic chan3_irq_in_n,
  input wire logic addr_strap_0,
  input wire logic addr_strap_1,
  input wire logic addr_strap_2
);
  logic scl_r, sda_r, frame_r;
  logic [4:0] cnt_r;
  logic [6:0] sh_r;
  logic [7:0] adr_r;
  logic [3:0] age_r;
  logic start_w, stop_w, rise_w, hit_w;
  logic [3:0] irq_w;
  assign start_w = scl_r && scl && sda_r && !sda;
  assign stop_w = scl_r && scl && !sda_r && sda;
  assign rise_w = !scl_r && scl;
  assign hit_w = adr_r[7:1] == {ADDR_HI, addr_strap_2, addr_strap_1, addr_strap_0};
  assign irq_w = {chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n};

  ////////////////////////////////////////////////////////////////////////
  // Bits counted from each start; the first byte is kept as the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      frame_r <= 1'b0;
      cnt_r <= 5'h0;
      sh_r <= 7'h0;
      adr_r <= 8'h0;
      age_r <= 4'hf;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      frame_r <= start_w || (frame_r && !stop_w);
      cnt_r <= start_w ? 5'h0 : cnt_r + {4'h0, rise_w};
      sh_r <= rise_w ? {sh_r[5:0], sda} : sh_r;
      adr_r <= (rise_w && cnt_r == 5'h7) ? {sh_r, sda} : adr_r;
      // Saturates so a long idle spell never looks like a fresh stop
      age_r <= stop_w ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RST_CLEAR: assert property ($rose(aresetn) |-> chan_select == 4'h0 && !sda_d_oe)
    else $error("select or data drive not clear after reset");
  AST_RST_IRQ: assert property ($rose(aresetn) && irq_w == 4'hf |=> !irq_oe)
    else $error("interrupt line pulled just after reset with all inputs high");
  AST_IRQ_LOW: assert property ((irq_w != 4'hf) [*5] |-> irq_oe)
    else $error("interrupt line not pulled with an input low");
  AST_IRQ_HIGH: assert property ((irq_w == 4'hf) [*5] |-> !irq_oe)
    else $error("interrupt line pulled with all inputs high");
  AST_ONE_HOT: assert property ($onehot0(chan_select))
    else $error("more than one channel selected");
  AST_SEL_AT_STOP: assert property (!$stable(chan_select) |-> age_r < 4'h8)
    else $error("channel select changed away from a stop");
  AST_IDLE_QUIET: assert property (!frame_r |-> !sda_d_oe)
    else $error("device pulls data line on idle bus");
  AST_DEV_SCL_LOW: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl))
    else $error("device moved data line while clock high");
  AST_ADDR_ACK: assert property (rise_w && cnt_r == 5'h8 |-> sda == !hit_w)
    else $error("address acknowledge does not match straps");
  AST_WRITE_ACK: assert property (rise_w && cnt_r == 5'h11 && hit_w && !adr_r[0] |-> !sda)
    else $error("written data byte not acknowledged");
  AST_NACK_FREE: assert property (rise_w && cnt_r == 5'h11 && hit_w && adr_r[0] |-> sda)
    else $error("device holds data line in read acknowledge slot");
  AST_MSB_IRQ3: assert property (rise_w && cnt_r == 5'h9 && hit_w && adr_r[0] |-> sda == !chan3_irq_in_n)
    else $error("read byte top bit does not show channel 3 interrupt");

  COV_FOREIGN: cover property (rise_w && cnt_r == 5'h8 && !hit_w);
  COV_READ: cover property (rise_w && cnt_r == 5'h9 && hit_w && adr_r[0]);
  COV_SELECT: cover property (!$stable(chan_select));
endmodule : ichmux_assertions

// [tb/tb_top.sv]
// Bench: AXI host controller driving the multiplexer across the two-wire link
`timescale 1ns/1ps
module tb_top;
  import ichmux_pkg::*;
  // Short quarter period keeps each frame near 620 cycles
  localparam int QTR = 8;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [6:0] DEV = {DEV_ADDR_HI, STRAP};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] irq_n = 4'hf;
  logic [2:0] strap = STRAP;
  logic [3:0] chan_select;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  always #5 aclk = ~aclk;

  ichmux_if ichmux_if_i ();
  ichmux_host #(.QTR(QTR)) ichmux_host_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus(ichmux_if_i.host));
  ichmux_dev #(.ADDR_HI(DEV_ADDR_HI)) ichmux_dev_i (.aclk(aclk), .aresetn(aresetn),
    .bus(ichmux_if_i.dev), .addr_strap_0(strap[0]), .addr_strap_1(strap[1]),
    .addr_strap_2(strap[2]), .chan0_irq_in_n(irq_n[0]), .chan1_irq_in_n(irq_n[1]),
    .chan2_irq_in_n(irq_n[2]), .chan3_irq_in_n(irq_n[3]), .chan_select(chan_select));
  ichmux_assertions #(.ADDR_HI(DEV_ADDR_HI)) ichmux_assertions_i (.aclk(aclk),
    .aresetn(aresetn), .scl(ichmux_if_i.scl), .sda(ichmux_if_i.sda),
    .sda_d_oe(ichmux_if_i.sda_d_oe), .irq_oe(ichmux_if_i.irq_oe), .chan_select(chan_select),
    .chan0_irq_in_n(irq_n[0]), .chan1_irq_in_n(irq_n[1]), .chan2_irq_in_n(irq_n[2]),
    .chan3_irq_in_n(irq_n[3]), .addr_strap_0(strap[0]), .addr_strap_1(strap[1]),
    .addr_strap_2(strap[2]));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // Each channel is released at the edge that takes it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_p = 1'b1;
    logic w_p = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      aw_p = aw_p && !awready;
      w_p = w_p && !wready;
      awvalid <= aw_p;
      wvalid <= w_p;
    end while (aw_p || w_p);
    while (bvalid !== 1'b1) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wait_idle(output logic [31:0] s);
    logic [1:0] r;
    do axi_rd(REG_STAT, s, r); while (s[ST_BUSY_BIT] !== 1'b0);
  endtask : wait_idle

  task automatic xfer(input logic [6:0] adr, input logic rd, input logic [7:0] d,
                      output logic [31:0] s);
    logic [1:0] r;
    axi_wr(REG_CMD, {9'h0, adr, d, 7'h0, rd}, r);
    check("cmd bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    wait_idle(s);
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] s;
    logic [1:0] r;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check("select after reset", 32'h0, {28'h0, chan_select});
    axi_rd(REG_STAT, s, r);
    check("stat after reset", 32'h4, {29'h0, s[2:0]});
    xfer(DEV, 1'b1, 8'h00, s);
    check("ctrl after reset", 32'h0, {24'h0, s[15:8]});
    axi_rd(8'h08, s, r);
    check("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_wr(8'h0c, 32'h0, r);
    check("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test reset done");
  endtask : t_reset

  task automatic t_select();
    logic [7:0] dat [6] = '{8'h03, 8'h04, 8'h05, 8'hf6, 8'h07, 8'h0b};
    logic [3:0] exp;
    logic [3:0] was;
    logic [31:0] s;
    logic [1:0] r;
    foreach (dat[i]) begin
      exp = dat[i][2] ? 4'h1 << dat[i][1:0] : 4'h0;
      was = chan_select;
      axi_wr(REG_CMD, {9'h0, DEV, dat[i], 8'h0}, r);
      // Lands in the acknowledge slot of the data byte, before the stop
      repeat (72 * QTR) @(posedge aclk);
      check("select before stop", {28'h0, was}, {28'h0, chan_select});
      wait_idle(s);
      check("write nack", 32'h0, {31'h0, s[ST_NACK_BIT]});
      check("select after stop", {28'h0, exp}, {28'h0, chan_select});
    end
    $display("test select done");
  endtask : t_select

  task automatic t_read();
    logic [3:0] pat [4] = '{4'hf, 4'h7, 4'h9, 4'h0};
    logic [31:0] s;
    xfer(DEV, 1'b0, 8'h06, s);
    foreach (pat[i]) begin
      irq_n <= pat[i];
      repeat (8) @(posedge aclk);
      check("irq line", {31'h0, pat[i] == 4'hf}, {31'h0, ichmux_if_i.irq_n});
      xfer(DEV, 1'b1, 8'h00, s);
      check("read byte", {24'h0, ~pat[i], 4'h6}, {24'h0, s[15:8]});
      check("stat irq", {31'h0, pat[i] == 4'hf}, {31'h0, s[ST_IRQ_BIT]});
    end
    irq_n <= 4'hf;
    $display("test read done");
  endtask : t_read

  task automatic t_wrong();
    logic [6:0] bad [3] = '{{DEV_ADDR_HI, ~STRAP}, {DEV_ADDR_HI, STRAP ^ 3'h1},
                            {~DEV_ADDR_HI, STRAP}};
    logic [3:0] was;
    logic [31:0] s;
    was = chan_select;
    foreach (bad[i]) begin
      xfer(bad[i], 1'b0, 8'h04, s);
      check("foreign nack", 32'h1, {31'h0, s[ST_NACK_BIT]});
      check("foreign select", {28'h0, was}, {28'h0, chan_select});
    end
    // Moving the straps must move the address that is answered
    strap <= 3'h2;
    xfer({DEV_ADDR_HI, 3'h2}, 1'b0, 8'h04, s);
    check("moved strap nack", 32'h0, {31'h0, s[ST_NACK_BIT]});
    check("moved strap select", 32'h1, {28'h0, chan_select});
    xfer(DEV, 1'b0, 8'h05, s);
    check("old strap nack", 32'h1, {31'h0, s[ST_NACK_BIT]});
    check("old strap select", 32'h1, {28'h0, chan_select});
    strap <= STRAP;
    $display("test foreign address done");
  endtask : t_wrong

  ////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    t_reset();
    t_select();
    t_read();
    t_wrong();
    t_reset();
    complete_run();
  end
endmodule : tb_top
